// File: hw/power_mode_ctrl.sv
// Run, wait, low-power run/wait and active background mode control.
// Assumes CPU pulses and debug requests are synchronous to pclk.
`timescale 1ns/100ps
module power_mode_ctrl (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      por_event,
    input  wire logic                      forced_debug_reset,
    input  wire logic                      debug_pin,
    input  wire logic                      wait_executed,
    input  wire logic                      enter_debug_instruction,
    input  wire logic                      breakpoint_hit,
    input  wire logic                      irq_request,
    input  wire power_mode_pkg::debug_req_t debug_req,
    output power_mode_pkg::debug_rsp_t     debug_rsp,
    output logic                           regulator_standby,
    output logic                           voltage_detect_enable,
    output logic                           cpu_clock_run,
    output logic                           clear_irq_mask,
    output logic                           stack_for_irq,
    output logic                           clock_cap_active,
    output logic                           clock_cap_tick,
    output logic [15:0]                    start_vector_addr
);
    power_mode_pkg::mode_t mode;
    power_mode_pkg::mode_t next_mode;
    logic       low_power_run_request;
    logic       wake_full_regulation_on_irq;
    logic       wake_bit_at_wait;
    logic       reset_strap_pending;
    logic [9:0] cap_count;

    wire apb_access  = psel & penable;
    wire apb_write   = apb_access & pwrite;
    wire hit_ctrl    = paddr == power_mode_pkg::CTRL_ADDR;
    wire hit_status  = paddr == power_mode_pkg::STATUS_ADDR;
    wire addr_ok     = hit_ctrl | hit_status;
    wire ctrl_write  = apb_write & hit_ctrl;
    wire req_wdata   = pwdata[power_mode_pkg::REQ_BIT];
    wire wake_wdata  = pwdata[power_mode_pkg::WAKE_BIT];

    wire in_bg       = mode == power_mode_pkg::BACKGROUND;
    wire in_wait     = mode == power_mode_pkg::WAIT_FULL
                     | mode == power_mode_pkg::LP_WAIT;
    wire in_lp       = mode == power_mode_pkg::LP_RUN
                     | mode == power_mode_pkg::LP_WAIT;

    wire cmd_bg      = debug_req.cmd == power_mode_pkg::CMD_BKGND;
    wire cmd_stat    = debug_req.cmd == power_mode_pkg::CMD_MEM_STAT;
    wire cmd_intr    = debug_req.cmd == power_mode_pkg::CMD_CPU_REG
                     | debug_req.cmd == power_mode_pkg::CMD_TRACE
                     | debug_req.cmd == power_mode_pkg::CMD_GO;
    wire cmd_go      = debug_req.valid & in_bg
                     & debug_req.cmd == power_mode_pkg::CMD_GO;
    wire bg_cmd_seen = debug_req.valid & cmd_bg;

    // Background entry sources
    wire bg_entry    = bg_cmd_seen                                     // R11
                     | enter_debug_instruction | breakpoint_hit
                     | (reset_strap_pending & ~debug_pin);

    // Wake-bit irq exits low power to full regulation
    wire irq_wakes_full = irq_request & (in_wait ? wake_bit_at_wait
                                                 : wake_full_regulation_on_irq);

    always_comb begin
        next_mode = mode;
        unique case (mode)
            power_mode_pkg::RUN: begin
                if (bg_entry)
                    next_mode = power_mode_pkg::BACKGROUND;
                else if (wait_executed)
                    next_mode = power_mode_pkg::WAIT_FULL;
                else if (low_power_run_request)
                    next_mode = power_mode_pkg::LP_RUN;            // R5
            end
            power_mode_pkg::LP_RUN: begin
                if (bg_entry)
                    next_mode = power_mode_pkg::BACKGROUND;
                else if (irq_wakes_full)
                    next_mode = power_mode_pkg::RUN;               // R9
                else if (wait_executed)
                    next_mode = power_mode_pkg::LP_WAIT;           // R19
                else if (!low_power_run_request)
                    next_mode = power_mode_pkg::RUN;               // R6
            end
            power_mode_pkg::WAIT_FULL: begin
                if (bg_cmd_seen)
                    next_mode = power_mode_pkg::BACKGROUND;        // R18
                else if (irq_request)
                    next_mode = power_mode_pkg::RUN;               // R16
            end
            power_mode_pkg::LP_WAIT: begin
                if (bg_cmd_seen)
                    next_mode = power_mode_pkg::BACKGROUND;        // R18
                else if (irq_wakes_full)
                    next_mode = power_mode_pkg::RUN;               // R21
                else if (irq_request)
                    next_mode = power_mode_pkg::LP_RUN;            // R20
            end
            power_mode_pkg::BACKGROUND: begin
                if (cmd_go)
                    next_mode = low_power_run_request
                              ? power_mode_pkg::LP_RUN
                              : power_mode_pkg::RUN;
            end
        endcase
    end

    // Mode register; reset always lands in normal run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mode <= power_mode_pkg::RUN;                            // R10 R22
        else
            mode <= next_mode;                                      // R23
    end

    // Hardware clear on full-regulation wake beats a software write
    wire next_req = irq_wakes_full & in_lp ? 1'b0                   // R9 R21
                  : ctrl_write ? req_wdata                          // R5 R6
                  : low_power_run_request;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_power_run_request       <= 1'b0;                    // R10 R22
            wake_full_regulation_on_irq <= 1'b0;
        end else begin
            low_power_run_request <= next_req;                      // R23
            if (ctrl_write)
                wake_full_regulation_on_irq <= wake_wdata;
        end
    end

    // Wake choice frozen when WAIT executes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wake_bit_at_wait <= 1'b0;
        else if (wait_executed & ~in_wait)
            wake_bit_at_wait <= wake_full_regulation_on_irq;
    end

    // Debug pin sampled after power-on or forced debug reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            reset_strap_pending <= 1'b0;
        else
            reset_strap_pending <= por_event | forced_debug_reset;
    end

    // Clock cap tick for low-power modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cap_count <= '0;
        else if (!in_lp || cap_count == power_mode_pkg::CLOCK_DIV - 10'h001)
            cap_count <= '0;
        else
            cap_count <= cap_count + 10'h001;
    end

    // Debug command acceptance by mode
    wire cmd_ok = in_bg ? 1'b1                                      // R13 R14
                : in_wait ? (cmd_bg | cmd_stat)                     // R17
                : ~cmd_intr;                                        // R14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_rsp <= '0;
        end else begin
            debug_rsp.accepted   <= debug_req.valid & cmd_ok;
            debug_rsp.rejected   <= debug_req.valid & ~cmd_ok;
            debug_rsp.wait_error <= debug_req.valid & in_wait
                                  & cmd_stat;                       // R17
        end
    end

    wire [31:0] ctrl_rdata = {30'h0, wake_full_regulation_on_irq,
                              low_power_run_request};
    // Status bit follows the registered mode, not the request
    wire [31:0] stat_rdata = {27'h0, debug_rsp.wait_error,
                              3'(mode), in_lp};                     // R7

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= '0;
        else if (psel & ~penable & ~pwrite)
            prdata <= hit_ctrl ? ctrl_rdata
                    : hit_status ? stat_rdata : 32'h0;
    end

    assign pready  = 1'b1;
    assign pslverr = apb_access & ~addr_ok;

    assign regulator_standby     = in_lp;                           // R2 R19
    assign voltage_detect_enable = ~in_lp;                          // R4
    assign clock_cap_active      = in_lp;                           // R2
    assign clock_cap_tick        = in_lp
                                 & cap_count == 10'h000;            // R2
    assign cpu_clock_run         = ~in_wait & ~in_bg;               // R12 R15
    assign clear_irq_mask        = wait_executed & ~in_wait
                                 & ~in_bg;                          // R15
    assign stack_for_irq         = in_wait & irq_request
                                 & ~bg_cmd_seen;                    // R16 R8
    assign start_vector_addr     = power_mode_pkg::RESET_VECTOR_ADDR; // R1

endmodule // power_mode_ctrl

// File: hw/power_mode_pkg.sv
// Constants, types and register map for the power mode controller.
// Assumes an APB master on pclk and CPU/debug sideband signals.
// Notes on behaviour
// R1: After reset, fetch start from top vectors
// R2: Low-power run: regulator standby, clocks capped
// R3: Software meets clock and detect preconditions first
// R4: Low-power run disables voltage detect and warning
// R5: Setting request bit enters regulator standby
// R6: Clearing request bit restores full regulation
// R7: Read-only status bit; zero means full regulation
// R8: Wake bit clear: serve interrupts in low power
// R9: Wake bit set: interrupt clears request, status
// R10: Reset ends low-power run, clears bits
// R11: Six events enter active background mode; the code decodes five
// R12: Background mode suspends CPU awaiting commands
// R13: Non-intrusive commands accepted in run, background
// R14: Intrusive commands only in background mode
// R15: Wait stops CPU clock, clears interrupt mask
// R16: Interrupt leaves wait, stacks context
// R17: Wait: only background and status commands; error
// R18: Background command in wait enters background
// R19: Wait in low-power run enters low-power wait
// R20: Wake bit clear: irq returns to low-power run
// R21: Wake bit set: irq returns full run, clears
// R22: Reset ends low-power wait, clears bits
// R23: Mode and bit updates registered on pclk
package power_mode_pkg;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
    localparam int          CLOCK_CAP_KHZ     = 125;
    localparam int          PCLK_KHZ          = 40000;
    localparam int          CLOCK_DIV_RAW     = (PCLK_KHZ + CLOCK_CAP_KHZ - 1)
                                                / CLOCK_CAP_KHZ;
    localparam logic [9:0]  CLOCK_DIV         = CLOCK_DIV_RAW[9:0];

    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;

    localparam int REQ_BIT     = 0;
    localparam int WAKE_BIT    = 1;
    localparam int STBY_BIT    = 0;
    localparam int MODE_LSB    = 1;
    localparam int DBG_ERR_BIT = 4;

    typedef enum {
        RUN, LP_RUN, WAIT_FULL, LP_WAIT, BACKGROUND
    } mode_t;

    typedef enum logic [2:0] {
        CMD_MEM      = 3'h0,
        CMD_MEM_STAT = 3'h1,
        CMD_DBG_REG  = 3'h2,
        CMD_BKGND    = 3'h3,
        CMD_CPU_REG  = 3'h4,
        CMD_TRACE    = 3'h5,
        CMD_GO       = 3'h6
    } debug_cmd_t;

    typedef struct packed {
        logic       valid;
        debug_cmd_t cmd;
    } debug_req_t;

    typedef struct packed {
        logic accepted;
        logic rejected;
        logic wait_error;
    } debug_rsp_t;
endpackage

// File: verif/debug_host_model.sv
// Serial debug host: issues one command pulse and takes the answer.
// Assumes the controller answers one cycle after taking the command.
`timescale 1ns/100ps
module debug_host_model (
    input  wire logic                       pclk,
    output power_mode_pkg::debug_req_t      debug_req,
    input  wire power_mode_pkg::debug_rsp_t debug_rsp
);
    initial debug_req = '0;
    task automatic send(input logic [2:0] c,
                        output power_mode_pkg::debug_rsp_t r);
        @(posedge pclk);
        debug_req <= {1'b1, power_mode_pkg::debug_cmd_t'(c)};
        @(posedge pclk);
        debug_req <= '0;
        @(posedge pclk);
        r = debug_rsp;
    endtask
endmodule // debug_host_model

// File: verif/power_mode_assertions.sv
// Concurrent checks on the power mode controller's ports.
// Bound into power_mode_ctrl from the testbench top file.
`timescale 1ns/100ps
module power_mode_assertions (
    input wire logic pclk, presetn, psel, penable, pwrite, cpu_clock_run,
    input wire logic wait_executed, regulator_standby, clear_irq_mask,
    input wire logic voltage_detect_enable, stack_for_irq,
    input wire logic clock_cap_tick, clock_cap_active,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [15:0] start_vector_addr,
    input wire power_mode_pkg::debug_req_t debug_req,
    input wire power_mode_pkg::debug_rsp_t debug_rsp
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] gap;
    // Cycles since the last capped-clock tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) gap <= 10'h000;
        else if (clock_cap_tick || !clock_cap_active) gap <= 10'h000;
        else gap <= gap + 10'h001;
    end
    sequence ctrl_wr(bit v);
        psel && penable && pwrite && cpu_clock_run && pwdata[0] == v
            && paddr == power_mode_pkg::CTRL_ADDR;
    endsequence
    sequence intrusive_run;
        debug_req.valid && cpu_clock_run
            && debug_req.cmd >= power_mode_pkg::CMD_CPU_REG;
    endsequence
    vector_fixed_a: assert property (start_vector_addr == 16'hFFFE)
        else $error("start vector wrong");
    cap_follow_a: assert property (clock_cap_active == regulator_standby)
        else $error("clock cap not tied to standby");
    tick_gap_a: assert property (gap <= 10'h140)
        else $error("capped tick too late");
    detect_off_a: assert property (voltage_detect_enable != regulator_standby)
        else $error("voltage detect on in standby");
    lp_enter_a: assert property (ctrl_wr(1) ##0 !regulator_standby
        |-> ##[1:2] regulator_standby) else $error("standby not entered");
    lp_leave_a: assert property (ctrl_wr(0) ##0 regulator_standby
        |-> ##[1:2] !regulator_standby) else $error("standby not left");
    wait_stop_a: assert property (wait_executed && cpu_clock_run
        |-> clear_irq_mask ##1 !cpu_clock_run) else $error("wait entry wrong");
    irq_wake_a: assert property (stack_for_irq |=> cpu_clock_run)
        else $error("irq did not leave wait");
    intrusive_ref_a: assert property (intrusive_run |=> debug_rsp.rejected)
        else $error("intrusive command not refused");
    rsp_given_a: assert property (debug_req.valid |=> $countones(debug_rsp) > 0)
        else $error("debug command unanswered");
endmodule // power_mode_assertions

// File: verif/testbench.sv
// Self-checking bench for the power mode controller with a mode model.
// Assumes the checker and debug host model are compiled first.
`timescale 1ns/100ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, debug_pin, err;
    logic        por_event, forced_debug_reset, wait_executed, pready;
    logic        enter_debug_instruction, breakpoint_hit, irq_request;
    logic        pslverr, regulator_standby, voltage_detect_enable;
    logic        cpu_clock_run, clear_irq_mask, stack_for_irq;
    logic        clock_cap_active, clock_cap_tick;
    logic [5:0]  evs;
    logic [11:0] paddr;
    logic [15:0] start_vector_addr;
    logic [31:0] pwdata, prdata, rd;
    power_mode_pkg::debug_req_t debug_req;
    power_mode_pkg::debug_rsp_t debug_rsp, rsp;
    int err_total = 0, checked = 0, seed = 50, mode, req, wake;
    int cmds[13] = '{0, 1, 2, 4, 5, 6, 3, 0, 1, 2, 4, 5, 6};
    assign {por_event, forced_debug_reset, wait_executed,
            enter_debug_instruction, breakpoint_hit, irq_request} = evs;
    power_mode_ctrl dut (.*);
    debug_host_model host (.pclk(pclk), .debug_req(debug_req),
                           .debug_rsp(debug_rsp));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        err_total++;
        results();
    end
    task results();
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task st();
        apb(1'b0, power_mode_pkg::STATUS_ADDR, 32'h0);
        chk(rd & 32'hF, {mode[2:0], 1'(mode == 1 || mode == 3)});
        apb(1'b0, power_mode_pkg::CTRL_ADDR, 32'h0);
        chk(rd & 32'h3, {wake[0], req[0]});
        chk(cpu_clock_run, mode < 2);
        chk(regulator_standby, mode == 1 || mode == 3);
        $display("Step done in mode %0d", mode);
    endtask
    task wr(input int v);
        apb(1'b1, power_mode_pkg::CTRL_ADDR, v);
        req = v & 1;
        wake = (v >> 1) & 1;
        if (mode < 2) mode = req;
    endtask
    task rst();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        {mode, req, wake} = 0;
    endtask
    task ev(input logic [5:0] v);
        @(posedge pclk);
        evs <= v;
        @(posedge pclk);
        evs <= 6'h00;
        repeat (2) @(posedge pclk);
        if (v[3] && mode < 2) mode = mode + 2;
        if (v[0] && mode[0] && wake) req = 0;
        if (v[0] && mode != 4) mode = mode[0] && !wake;
        if ((|v[5:4] && !debug_pin) || |v[2:1]) mode = 4;
        st();
    endtask
    task dbg(input int c);
        int w, x;
        w = (mode == 2 || mode == 3);
        x = w ? c != 1 && c != 3 : mode != 4 && c > 3;
        host.send(c[2:0], rsp);
        chk(rsp.rejected, x);
        chk(rsp.accepted, !x);
        chk(rsp.wait_error, w && c == 1);
        if (c == 3) mode = 4;
        else if (c == 6 && mode == 4) mode = req;
        st();
    endtask
    initial begin
        {presetn, psel, penable, pwrite, debug_pin} = 5'b00001;
        {paddr, pwdata, evs} = '0;
        rst();
        chk(start_vector_addr, 16'hFFFE);
        st();
        wr(1);
        repeat (700) @(posedge pclk);
        chk(voltage_detect_enable, 1'b0);
        ev(6'h01);
        ev(6'h08);
        ev(6'h01);
        wr(3);
        ev(6'h01);
        wr(3);
        ev(6'h08);
        ev(6'h01);
        wr(1);
        wr(0);
        st();
        wr(1);
        rst();
        st();
        wr(1);
        ev(6'h08);
        rst();
        st();
        foreach (cmds[i]) dbg(cmds[i]);
        ev(6'h08);
        dbg(0);
        dbg(1);
        dbg(3);
        dbg(6);
        ev(6'h08);
        ev(6'h01);
        debug_pin <= 1'b0;
        ev(6'h20);
        dbg(6);
        ev(6'h10);
        debug_pin <= 1'b1;
        dbg(6);
        ev(6'h20);
        ev(6'h04);
        dbg(6);
        ev(6'h02);
        dbg(6);
        apb(1'b1, 12'h008, $random(seed));
        chk(err, 1'b1);
        st();
        results();
    end
endmodule // testbench
bind power_mode_ctrl power_mode_assertions chk_i (.*);
